// [inc/bie_pkg.sv]
// Purpose: Shared constants and types for the branch and interrupt-enable executor
// Assumes: 10-bit program counter, 8-bit data path
// Notes:   The opcode arrives as an enumerated code qualified by a valid bit
`default_nettype none
package bie_pkg;
	localparam int          PC_W          = 10;
	localparam int          ADR_W         = 9;
	localparam int          DATA_W        = 8;
	localparam logic [9:0]  PC_RESET      = 10'h000;
	localparam logic        INT_EN_RESET  = 1'b0;
	localparam int          PCH_BIT_IMM   = 1;
	localparam int          BRANCH_CYCLES = 2;
	localparam int          SINGLE_CYCLES = 1;

	typedef enum logic [2:0] {
		BIE_OP_NONE,
		BIE_OP_INT_OFF,
		BIE_OP_INT_ON,
		BIE_OP_BR_IMM,
		BIE_OP_BR_ACCUM
	} bie_op_t;

	// Instruction presented by the fetch stage
	typedef struct packed {
		logic       valid;
		bie_op_t    op;
		logic [8:0] adr;
	} bie_instr_t;

	// Core register values used to form branch targets
	typedef struct packed {
		logic [7:0] accumulator;
		logic [7:0] pc_high_buffer;
		logic [7:0] table_high_pointer;
	} bie_regs_t;
endpackage : bie_pkg
`default_nettype wire

// [hdl/bie_exec.sv]
// Purpose: Executes interrupt enable/disable and the two unconditional branches
// Assumes: Fetch stage holds one prefetched word and obeys flush_fetch
// Notes:   Branches stall the pipeline one cycle while the new address is fetched
//
// Operation
// - disable instruction clears global interrupt enable
// - enable instruction sets global interrupt enable
// - immediate branch: adr to PC[8:0], bit1 to PC[9]
// - immediate branch unconditional, no flags, two cycles
// - accumulator branch: pointer bits 1:0 to PC[9:8]
// - accumulator branch: accumulator to PC[7:0], two cycles
`timescale 1ns/1ps
`default_nettype none
module bie_exec
	import bie_pkg::*;
(
	input  wire logic              clock,             // Core clock, 25 MHz
	input  wire logic              reset,             // Asynchronous reset, active high
	input  wire bie_instr_t        instr,             // Decoded instruction from fetch
	input  wire bie_regs_t         regs,              // Core register values
	output logic                   global_int_enable, // Global interrupt enable flag
	output logic [PC_W-1:0]        pc,                // Program counter
	output logic                   pc_load,           // Pulse: pc was loaded by a branch
	output logic                   flush_fetch,       // Pulse: discard the prefetched word
	output logic                   busy,              // High during a branch second cycle
	output logic                   flags_write        // Status flag write strobe, never set
);
	logic            int_en_q, int_en_d;
	logic            flags_q, flags_d;
	logic [PC_W-1:0] pc_q,    pc_d;
	logic            load_q,  load_d;
	logic            flush_q, flush_d;
	logic            busy_q,  busy_d;
	logic            take;

	assign take = instr.valid && !busy_q;

	always_comb begin
		int_en_d = int_en_q;
		flags_d = 1'b0;
		pc_d    = pc_q;
		load_d  = 1'b0;
		flush_d = 1'b0;
		busy_d  = 1'b0;
		if (take) begin
			unique case (instr.op)
				BIE_OP_INT_OFF: int_en_d = 1'b0;
				BIE_OP_INT_ON: int_en_d = 1'b1;
				BIE_OP_BR_IMM: begin
					pc_d = {regs.pc_high_buffer[PCH_BIT_IMM], instr.adr};
					load_d  = 1'b1;
					busy_d  = 1'b1;
					flush_d = 1'b1;
				end
				BIE_OP_BR_ACCUM: begin
					pc_d    = {regs.table_high_pointer[1:0], regs.accumulator};
					load_d  = 1'b1;
					busy_d  = 1'b1;
					flush_d = 1'b1;
				end
				BIE_OP_NONE: begin
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			int_en_q <= INT_EN_RESET;
			flags_q <= 1'b0;
			pc_q    <= PC_RESET;
			load_q  <= 1'b0;
			flush_q <= 1'b0;
			busy_q  <= 1'b0;
		end else begin
			int_en_q <= int_en_d;
			flags_q <= flags_d;
			pc_q    <= pc_d;
			load_q  <= load_d;
			flush_q <= flush_d;
			busy_q  <= busy_d;
		end
	end

	assign global_int_enable = int_en_q;
	assign pc                = pc_q;
	assign pc_load           = load_q;
	assign flush_fetch       = flush_q;
	assign busy              = busy_q;
	// Status flags are untouched by all four instructions
	assign flags_write       = flags_q;

	property p_int_off;
		@(posedge clock) disable iff (reset)
		(take && instr.op == BIE_OP_INT_OFF) |=> !global_int_enable;
	endproperty
	a_int_off: assert property (p_int_off) else $error("disable did not clear enable");

	property p_int_on;
		@(posedge clock) disable iff (reset)
		(take && instr.op == BIE_OP_INT_ON) |=> global_int_enable;
	endproperty
	a_int_on: assert property (p_int_on) else $error("enable did not set enable");

	property p_br_imm;
		@(posedge clock) disable iff (reset)
		(take && instr.op == BIE_OP_BR_IMM) |=>
			pc == {$past(regs.pc_high_buffer[1]), $past(instr.adr)};
	endproperty
	a_br_imm: assert property (p_br_imm) else $error("immediate target wrong");

	property p_imm_low;
		@(posedge clock) disable iff (reset)
		(take && instr.op == BIE_OP_BR_IMM) |=>
			pc[ADR_W-1:0] == $past(instr.adr);
	endproperty
	a_imm_low: assert property (p_imm_low) else $error("immediate low bits wrong");

	property p_imm_high;
		@(posedge clock) disable iff (reset)
		(take && instr.op == BIE_OP_BR_IMM) |=>
			pc[PC_W-1] == $past(regs.pc_high_buffer[PCH_BIT_IMM]);
	endproperty
	a_imm_high: assert property (p_imm_high) else $error("immediate top bit wrong");

	property p_br_two;
		@(posedge clock) disable iff (reset)
		(take && (instr.op == BIE_OP_BR_IMM || instr.op == BIE_OP_BR_ACCUM))
			|=> busy ##1 !busy;
	endproperty
	a_br_two: assert property (p_br_two) else $error("branch not two cycles");

	property p_load_pulse;
		@(posedge clock) disable iff (reset)
		pc_load |=> !pc_load;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("load longer than a cycle");

	property p_br_accum;
		@(posedge clock) disable iff (reset)
		(take && instr.op == BIE_OP_BR_ACCUM) |=>
			pc == {$past(regs.table_high_pointer[1:0]), $past(regs.accumulator)};
	endproperty
	a_br_accum: assert property (p_br_accum) else $error("accumulator target wrong");

	property p_accum_high;
		@(posedge clock) disable iff (reset)
		(take && instr.op == BIE_OP_BR_ACCUM) |=>
			pc[PC_W-1:DATA_W] == $past(regs.table_high_pointer[1:0]);
	endproperty
	a_accum_high: assert property (p_accum_high) else $error("pointer bits wrong");

	property p_accum_low;
		@(posedge clock) disable iff (reset)
		(take && instr.op == BIE_OP_BR_ACCUM) |=>
			pc[DATA_W-1:0] == $past(regs.accumulator);
	endproperty
	a_accum_low: assert property (p_accum_low) else $error("accumulator byte wrong");

	property p_flags;
		@(posedge clock) disable iff (reset)
		!flags_write;
	endproperty
	a_flags: assert property (p_flags) else $error("status flags written");

	property p_flush;
		@(posedge clock) disable iff (reset)
		pc_load |-> flush_fetch && busy;
	endproperty
	a_flush: assert property (p_flush) else $error("branch without flush");

	property p_flush_branch;
		@(posedge clock) disable iff (reset)
		flush_fetch |-> pc_load;
	endproperty
	a_flush_branch: assert property (p_flush_branch) else $error("flush without branch");

	property p_int_single;
		@(posedge clock) disable iff (reset)
		(take && (instr.op == BIE_OP_INT_OFF || instr.op == BIE_OP_INT_ON))
			|=> !busy && !pc_load;
	endproperty
	a_int_single: assert property (p_int_single) else $error("enable change stalled");

	property p_int_en_hold;
		@(posedge clock) disable iff (reset)
		!(take && (instr.op == BIE_OP_INT_OFF || instr.op == BIE_OP_INT_ON))
			|=> $stable(global_int_enable);
	endproperty
	a_int_en_hold: assert property (p_int_en_hold) else $error("enable changed unasked");

	property p_busy_ignore;
		@(posedge clock) disable iff (reset)
		busy |=> !pc_load && $stable(global_int_enable);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("instruction taken while busy");

	property p_pc_hold;
		@(posedge clock) disable iff (reset)
		!pc_load |-> $stable(pc);
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("pc changed without load");
endmodule : bie_exec
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the branch and interrupt-enable executor
// Assumes: Inputs are driven at the rising edge; outputs are read 1 ns after it
// Notes:   Each scenario is one task; end_sim gives the verdict
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import bie_pkg::*;
;
	logic             clock;
	logic             reset;
	bie_instr_t       instr;
	bie_regs_t        regs;
	logic             global_int_enable;
	logic [PC_W-1:0]  pc;
	logic             pc_load;
	logic             flush_fetch;
	logic             busy;
	logic             flags_write;
	int               failures;
	int               checked;

	bie_exec bie_exec_i (.clock(clock), .reset(reset), .instr(instr), .regs(regs),
		.global_int_enable(global_int_enable), .pc(pc), .pc_load(pc_load),
		.flush_fetch(flush_fetch), .busy(busy), .flags_write(flags_write));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic end_sim;
		if (failures == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Present one instruction, then a follow-up during the cycle after it is taken
	task automatic send(input bie_op_t op, input logic [8:0] adr, input bie_op_t fop);
		@(posedge clock);
		instr <= '{valid: 1'b1, op: op, adr: adr};
		@(posedge clock);
		instr <= '{valid: (fop != BIE_OP_NONE), op: fop, adr: 9'h000};
		#1;
	endtask : send

	// Back-to-back enable and disable, then a valid no-operation
	task automatic t_int;
		send(BIE_OP_INT_ON, 9'h000, BIE_OP_INT_OFF);
		chk("enable", 10'h001, {9'h000, global_int_enable});
		@(posedge clock);
		instr <= '{valid: 1'b1, op: BIE_OP_NONE, adr: 9'h155};
		#1;
		chk("enable", 10'h000, {9'h000, global_int_enable});
		chk("pulses", 10'h000, {7'h00, pc_load, flush_fetch, busy});
		@(posedge clock);
		instr <= '0;
		#1;
		chk("enable", 10'h000, {9'h000, global_int_enable});
		chk("pc", 10'h000, pc);
		chk("flags", 10'h000, {9'h000, flags_write});
		send(BIE_OP_INT_ON, 9'h000, BIE_OP_NONE);
		chk("enable", 10'h001, {9'h000, global_int_enable});
	endtask : t_int

	// Immediate branch; a disable offered in the busy cycle is ignored
	task automatic t_imm;
		@(posedge clock);
		regs.pc_high_buffer <= 8'h02;
		send(BIE_OP_BR_IMM, 9'h1ff, BIE_OP_INT_OFF);
		chk("pc", 10'h3ff, pc);
		chk("pulses", 10'h007, {7'h00, pc_load, flush_fetch, busy});
		@(posedge clock);
		instr <= '0;
		regs.pc_high_buffer <= 8'hfd;
		#1;
		chk("enable", 10'h001, {9'h000, global_int_enable});
		chk("pulses", 10'h000, {7'h00, pc_load, flush_fetch, busy});
		chk("pc", 10'h3ff, pc);
		send(BIE_OP_BR_IMM, 9'h0a5, BIE_OP_NONE);
		chk("pc", 10'h0a5, pc);
		chk("flags", 10'h000, {9'h000, flags_write});
	endtask : t_imm

	task automatic t_accum;
		@(posedge clock);
		regs <= '{accumulator: 8'h34, pc_high_buffer: 8'h00, table_high_pointer: 8'hfe};
		send(BIE_OP_BR_ACCUM, 9'h1ff, BIE_OP_NONE);
		chk("pc", 10'h234, pc);
		chk("pulses", 10'h007, {7'h00, pc_load, flush_fetch, busy});
		@(posedge clock);
		#1;
		chk("pulses", 10'h000, {7'h00, pc_load, flush_fetch, busy});
		chk("pc", 10'h234, pc);
	endtask : t_accum

	initial begin
		failures = 0;
		checked = 0;
		reset = 1'b1;
		instr = '0;
		regs = '0;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		#1;
		chk("pc", 10'h000, pc);
		chk("enable", 10'h000, {9'h000, global_int_enable});
		t_int;
		t_imm;
		t_accum;
		end_sim;
	end

	initial begin
		#20000;
		failures++;
		end_sim;
	end
endmodule : tb_top
`default_nettype wire
